// ---- design/flmr_top.sv ----
// Fault latch and error mask register bank of the supply supervisor.
// Assumes the serial register engine drives the register port on CLOCK.
`timescale 1ns/10ps
`default_nettype none
`include "flmr_defines.svh"

module flmr_top (
    input  wire logic                        CLOCK,
    input  wire logic                        SYS_RST,
    input  wire logic [`FLMR_SUPPLY_MSB:0]   SUPPLY_FAULT_DETECTOR,
    input  wire logic [3:0]                  GENERAL_INPUT,
    input  wire logic                        WATCHDOG_DETECTOR_INPUT,
    input  wire logic [7:0]                  REG_ADDR,
    input  wire logic                        REG_WR,
    input  wire logic [7:0]                  REG_WDATA,
    input  wire logic                        REG_RD,
    output logic      [7:0]                  REG_RDATA,
    output logic                             SUMMARY_FAULT_FLAG
);
    flmr_if mon ();

    flmr_pkg::flmr_byte_t   supply_error_mask;
    flmr_pkg::flmr_byte_t   input_watchdog_error_mask;
    flmr_pkg::flmr_byte_t   supply_fault_latch;
    flmr_pkg::flmr_byte_t   input_watchdog_fault_latch;
    flmr_pkg::flmr_byte_t   rdata;
    flmr_pkg::flmr_byte_t   next_supply_error_mask;
    flmr_pkg::flmr_byte_t   next_input_watchdog_error_mask;
    flmr_pkg::flmr_byte_t   next_supply_fault_latch;
    flmr_pkg::flmr_byte_t   next_input_watchdog_fault_latch;
    flmr_pkg::flmr_byte_t   next_rdata;
    flmr_pkg::flmr_supply_t supply_chg;
    flmr_pkg::flmr_input_t  input_chg;
    flmr_pkg::flmr_supply_t supply_keep;
    flmr_pkg::flmr_input_t  input_keep;
    logic                   any_log;
    logic                   clear_rd;
    flmr_pkg::flmr_supply_t supply_open;
    flmr_pkg::flmr_input_t  input_open;

    // Pack the monitored lines: supplies low, inputs, watchdog on top
    assign mon.raw = {WATCHDOG_DETECTOR_INPUT, GENERAL_INPUT,
                      SUPPLY_FAULT_DETECTOR};

    flmr_change_det u_det (
        .clk (CLOCK),
        .rst (SYS_RST),
        .mon (mon)
    );

    // Only unmasked changes are logged
    assign supply_chg = mon.changed[`FLMR_SUPPLY_MSB:0]
                        & ~supply_error_mask[`FLMR_SUPPLY_MSB:0];
    assign input_chg  = mon.changed[`FLMR_MON_WIDTH-1:`FLMR_MON_INPUT_LSB]
                        & ~input_watchdog_error_mask[`FLMR_INPUT_MSB:0];
    assign any_log    = (|supply_chg) || (|input_chg);
    assign clear_rd   = REG_RD && (REG_ADDR == `FLMR_OFS_INPUT_LATCH);

    // Masks as they stand after this edge; a bit masked now reads 0 at once,
    // otherwise a read right after the mask write could still see it
    assign supply_open = ~next_supply_error_mask[`FLMR_SUPPLY_MSB:0];
    assign input_open  = ~next_input_watchdog_error_mask[`FLMR_INPUT_MSB:0];

    // A mask set later also forces an already latched bit back to 0
    assign supply_keep = supply_fault_latch[`FLMR_SUPPLY_MSB:0]
                         & supply_open;
    assign input_keep  = input_watchdog_fault_latch[`FLMR_INPUT_MSB:0]
                         & input_open;

    // Mask registers: writable, bit 7 of the first and bits 7:5 of the second have no storage
    always_comb begin
        next_supply_error_mask         = supply_error_mask;
        next_input_watchdog_error_mask = input_watchdog_error_mask;
        if (REG_WR && REG_ADDR == `FLMR_OFS_SUPPLY_MASK) begin
            next_supply_error_mask = {1'b0,
                REG_WDATA[`FLMR_SUPPLY_MSB:0]};
        end
        if (REG_WR && REG_ADDR == `FLMR_OFS_INPUT_MASK) begin
            next_input_watchdog_error_mask = {3'b000,
                REG_WDATA[`FLMR_INPUT_MSB:0]};
        end
    end

    // Latches: an event in the clearing cycle wins over the clear
    always_comb begin
        next_supply_fault_latch = {supply_fault_latch[`FLMR_SUMMARY_BIT],
                                   supply_keep};
        next_input_watchdog_fault_latch = {3'b000, input_keep};
        if (clear_rd) begin
            next_supply_fault_latch         = `FLMR_RST_LATCH;
            next_input_watchdog_fault_latch = `FLMR_RST_LATCH;
        end
        if (any_log) begin
            // Snapshot of detector levels taken at the logged event
            next_supply_fault_latch = {1'b1,
                mon.level[`FLMR_SUPPLY_MSB:0] & supply_open};
        end
        if (|input_chg) begin
            next_input_watchdog_fault_latch = {3'b000,
                next_input_watchdog_fault_latch[`FLMR_INPUT_MSB:0]
                | (input_chg & input_open)};
        end
    end

    // Read mux; unused bits and unmapped offsets read as zero
    always_comb begin
        next_rdata = rdata;
        if (REG_RD) begin
            case (REG_ADDR)
                `FLMR_OFS_SUPPLY_MASK:  next_rdata = supply_error_mask;
                `FLMR_OFS_INPUT_MASK:   next_rdata = input_watchdog_error_mask;
                `FLMR_OFS_SUPPLY_LATCH: next_rdata = supply_fault_latch;
                `FLMR_OFS_INPUT_LATCH:  next_rdata = input_watchdog_fault_latch;
                default:                next_rdata = `FLMR_RDATA_UNMAPPED;
            endcase
        end
    end

    // Latches have no write path; software alters them only by the clearing read or a mask write
    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            supply_error_mask          <= `FLMR_RST_MASK;
            input_watchdog_error_mask  <= `FLMR_RST_MASK;
            supply_fault_latch         <= `FLMR_RST_LATCH;
            input_watchdog_fault_latch <= `FLMR_RST_LATCH;
            rdata                      <= `FLMR_RDATA_UNMAPPED;
        end else begin
            supply_error_mask          <= next_supply_error_mask;
            input_watchdog_error_mask  <= next_input_watchdog_error_mask;
            supply_fault_latch         <= next_supply_fault_latch;
            input_watchdog_fault_latch <= next_input_watchdog_fault_latch;
            rdata                      <= next_rdata;
        end
    end

    // Outputs straight from flops
    assign REG_RDATA          = rdata;
    assign SUMMARY_FAULT_FLAG = supply_fault_latch[`FLMR_SUMMARY_BIT];

    // Checks on the register bank
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (SYS_RST);

    reset_zero_a: assert property ($past(SYS_RST) |->
        supply_fault_latch == 8'h00 && input_watchdog_fault_latch == 8'h00
        && supply_error_mask == 8'h00 && input_watchdog_error_mask == 8'h00)
        else $error("Registers not zero after reset");

    supply_snap_a: assert property (|supply_chg |=>
        supply_fault_latch[6:0] == ($past(mon.level[6:0])
        & ~supply_error_mask[6:0]))
        else $error("Supply latch does not match detector levels");

    summary_set_a: assert property (any_log |=>
        SUMMARY_FAULT_FLAG ##1 (REG_RDATA[7] || !$past(REG_RD)
        || $past(REG_ADDR) != 8'hDC))
        else $error("Summary flag missed a logged change");

    input_flag_a: assert property (|input_chg |=>
        (input_watchdog_fault_latch[4:0] & $past(input_chg)
        & ~input_watchdog_error_mask[4:0])
        == ($past(input_chg) & ~input_watchdog_error_mask[4:0]))
        else $error("Input or watchdog change not logged");

    latch_ro_a: assert property (REG_WR && !any_log && !clear_rd
        && REG_ADDR inside {8'hDC, 8'hDD}
        && supply_error_mask == next_supply_error_mask
        && input_watchdog_error_mask == next_input_watchdog_error_mask
        |=> $stable(supply_fault_latch)
        && $stable(input_watchdog_fault_latch))
        else $error("Fault latch changed on a write");

    supply_mask_a: assert property (
        (supply_fault_latch[6:0] & supply_error_mask[6:0]) == 7'h00)
        else $error("Masked supply bit is set");

    input_mask_a: assert property (
        (input_watchdog_fault_latch[4:0]
        & input_watchdog_error_mask[4:0]) == 5'h00)
        else $error("Masked input bit is set");

    mask_rw_a: assert property (REG_WR && REG_ADDR == 8'h9E
        ##1 (REG_RD && REG_ADDR == 8'h9E && !REG_WR)
        |=> REG_RDATA == {3'b000, $past(REG_WDATA[4:0], 2)})
        else $error("Second mask readback mismatch");

    summary_nomask_a: assert property (
        supply_error_mask[7] == 1'b0 && input_watchdog_error_mask[7:5] == 3'h0
        && input_watchdog_fault_latch[7:5] == 3'h0)
        else $error("Unused bit holds a one");

    clear_read_a: assert property (clear_rd && !any_log |=>
        supply_fault_latch == 8'h00 && input_watchdog_fault_latch[4:0] == 5'h00)
        else $error("Clearing read left latches set");

    either_edge_a: assert property ($changed(mon.level[0])
        && !supply_error_mask[0] |-> any_log ##1 SUMMARY_FAULT_FLAG)
        else $error("Supply change not logged");

    hold_a: assert property (!any_log && !clear_rd && !REG_WR
        |=> $stable(supply_fault_latch) && $stable(input_watchdog_fault_latch))
        else $error("Latch changed without cause");

    dc_keep_a: assert property (REG_RD && REG_ADDR == 8'hDC
        && !REG_WR && !any_log |=> $stable(supply_fault_latch))
        else $error("Reading the first latch altered it");

    clear_cover_c: cover property (SUMMARY_FAULT_FLAG ##[1:50] clear_rd);
    mask_late_cover_c: cover property (REG_WR && REG_ADDR == 8'h9E
        && |input_watchdog_fault_latch[4:0]);
    race_cover_c: cover property (clear_rd && any_log);
    masked_cover_c: cover property (|mon.changed && !any_log);
endmodule

`default_nettype wire

// ---- design/flmr_defines.svh ----
// Offsets, field positions and reset values of the fault latch bank.
// Assumes inclusion by bare name from the package and the modules.
`ifndef FLMR_DEFINES_SVH
`define FLMR_DEFINES_SVH

// Register offsets on the internal register port
`define FLMR_OFS_SUPPLY_MASK   8'h9D
`define FLMR_OFS_INPUT_MASK    8'h9E
`define FLMR_OFS_SUPPLY_LATCH  8'hDC
`define FLMR_OFS_INPUT_LATCH   8'hDD

// Power-on values and the answer to an unmapped read
`define FLMR_RST_MASK          8'h00
`define FLMR_RST_LATCH         8'h00
`define FLMR_RDATA_UNMAPPED    8'h00

// Field positions
`define FLMR_SUMMARY_BIT       7
`define FLMR_SUPPLY_MSB        6
`define FLMR_INPUT_MSB         4
`define FLMR_WDOG_BIT          4

// Monitored vector: supplies 6:0, general inputs 10:7, watchdog 11
`define FLMR_MON_WIDTH         12
`define FLMR_MON_INPUT_LSB     7
`define FLMR_MON_RST           12'h000

`endif

// ---- design/flmr_pkg.sv ----
// Types shared by the fault latch bank modules.
// Assumes the defines header sits in the include path.
`include "flmr_defines.svh"

package flmr_pkg;
    typedef logic [7:0]                     flmr_byte_t;
    typedef logic [`FLMR_SUPPLY_MSB:0]      flmr_supply_t;
    typedef logic [`FLMR_INPUT_MSB:0]       flmr_input_t;
    typedef logic [`FLMR_MON_WIDTH-1:0]     flmr_mon_t;
endpackage

// ---- design/flmr_if.sv ----
// Carrier between the change detector and the register core.
// Assumes both ends run on the same clock.
`timescale 1ns/10ps
`default_nettype none

interface flmr_if;
    flmr_pkg::flmr_mon_t raw;
    flmr_pkg::flmr_mon_t level;
    flmr_pkg::flmr_mon_t changed;

    modport det  (input raw, output level, output changed);
    modport core (output raw, input level, input changed);
endinterface

`default_nettype wire

// ---- design/flmr_change_det.sv ----
// Synchroniser and level-change detector for the twelve monitored lines.
// Assumes raw lines are asynchronous to the clock.
`timescale 1ns/10ps
`default_nettype none
`include "flmr_defines.svh"

module flmr_change_det (
    input  wire logic clk,
    input  wire logic rst,
    flmr_if.det       mon
);
    flmr_pkg::flmr_mon_t sync1;
    flmr_pkg::flmr_mon_t sync2;
    flmr_pkg::flmr_mon_t prev;
    flmr_pkg::flmr_mon_t next_sync1;
    flmr_pkg::flmr_mon_t next_sync2;
    flmr_pkg::flmr_mon_t next_prev;

    // Two-stage sync, then one more stage as the last sampled value
    always_comb begin
        next_sync1 = mon.raw;
        next_sync2 = sync1;
        next_prev  = sync2;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            sync1 <= `FLMR_MON_RST;
            sync2 <= `FLMR_MON_RST;
            prev  <= `FLMR_MON_RST;
        end else begin
            sync1 <= next_sync1;
            sync2 <= next_sync2;
            prev  <= next_prev;
        end
    end

    // Either edge counts; sync1 feeds only sync2
    assign mon.level   = sync2;
    assign mon.changed = sync2 ^ prev;

    // Covers a rising and a falling change on the same line
    chg_cover_c: cover property (@(posedge clk) disable iff (rst)
        (mon.changed[0] && mon.level[0]) ##[1:20]
        (mon.changed[0] && !mon.level[0]));
endmodule

`default_nettype wire

// ---- testbench/test_flmr_top.sv ----
// Self-checking bench for the fault latch and error mask register bank.
// Assumes the design package and defines header are compiled before it.
`include "flmr_defines.svh"
`timescale 1ns/10ps
`default_nettype none

module test_flmr_top;
    logic       CLOCK                   = 1'b0;
    logic       SYS_RST                 = 1'b1;
    logic [6:0] SUPPLY_FAULT_DETECTOR   = 7'h00;
    logic [3:0] GENERAL_INPUT           = 4'h0;
    logic       WATCHDOG_DETECTOR_INPUT = 1'b0;
    logic [7:0] REG_ADDR                = 8'h00;
    logic       REG_WR                  = 1'b0;
    logic [7:0] REG_WDATA               = 8'h00;
    logic       REG_RD                  = 1'b0;
    logic [7:0] REG_RDATA;
    logic       SUMMARY_FAULT_FLAG;
    int         n_errors                = 0;
    int         check_count             = 0;

    flmr_top flmr_top_i (
        .CLOCK                   (CLOCK),
        .SYS_RST                 (SYS_RST),
        .SUPPLY_FAULT_DETECTOR   (SUPPLY_FAULT_DETECTOR),
        .GENERAL_INPUT           (GENERAL_INPUT),
        .WATCHDOG_DETECTOR_INPUT (WATCHDOG_DETECTOR_INPUT),
        .REG_ADDR                (REG_ADDR),
        .REG_WR                  (REG_WR),
        .REG_WDATA               (REG_WDATA),
        .REG_RD                  (REG_RD),
        .REG_RDATA               (REG_RDATA),
        .SUMMARY_FAULT_FLAG      (SUMMARY_FAULT_FLAG)
    );

    // 40 MHz clock
    always #12.5 CLOCK = ~CLOCK;

    // Compare tasks, case equality so unknowns never match
    task automatic check8(input string what, input logic [7:0] exp,
                          input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic check1(input string what, input logic exp,
                          input logic got);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %s expected %b seen %b", what, exp, got);
        end
    endtask

    // One-cycle strobes launched and dropped at falling edges
    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        @(negedge CLOCK);
        REG_ADDR  = addr;
        REG_WDATA = data;
        REG_WR    = 1'b1;
        @(negedge CLOCK);
        REG_WR    = 1'b0;
    endtask

    // Data is settled by the falling edge after the taking edge
    task automatic rd(input logic [7:0] addr, input logic [7:0] exp);
        @(negedge CLOCK);
        REG_ADDR = addr;
        REG_RD   = 1'b1;
        @(negedge CLOCK);
        REG_RD   = 1'b0;
        check8($sformatf("reg %h", addr), exp, REG_RDATA);
    endtask

    // Six cycles cover two sync stages plus the logging edge
    task automatic set_lines(input logic [6:0] s, input logic [3:0] g,
                             input logic w);
        @(negedge CLOCK);
        SUPPLY_FAULT_DETECTOR   = s;
        GENERAL_INPUT           = g;
        WATCHDOG_DETECTOR_INPUT = w;
        repeat (6) @(negedge CLOCK);
    endtask

    // Write, then read the same offset in the very next cycle
    task automatic wr_rd(input logic [7:0] addr, input logic [7:0] data,
                         input logic [7:0] exp);
        @(negedge CLOCK);
        REG_ADDR  = addr;
        REG_WDATA = data;
        REG_WR    = 1'b1;
        @(negedge CLOCK);
        REG_WR    = 1'b0;
        REG_RD    = 1'b1;
        @(negedge CLOCK);
        REG_RD    = 1'b0;
        check8($sformatf("reg %h", addr), exp, REG_RDATA);
    endtask

    // Power-on values, access kinds, refused writes
    task automatic test_regs();
        rd(`FLMR_OFS_SUPPLY_MASK, 8'h00);
        rd(`FLMR_OFS_INPUT_MASK, 8'h00);
        rd(`FLMR_OFS_SUPPLY_LATCH, 8'h00);
        rd(`FLMR_OFS_INPUT_LATCH, 8'h00);
        wr_rd(`FLMR_OFS_SUPPLY_MASK, 8'hFF, 8'h7F);
        wr_rd(`FLMR_OFS_INPUT_MASK, 8'hF5, 8'h15);
        wr(`FLMR_OFS_SUPPLY_LATCH, 8'hFF);
        wr(`FLMR_OFS_INPUT_LATCH, 8'hFF);
        wr(8'h55, 8'hFF);
        rd(`FLMR_OFS_SUPPLY_LATCH, 8'h00);
        rd(`FLMR_OFS_INPUT_LATCH, 8'h00);
        rd(8'h55, 8'h00);
        wr(`FLMR_OFS_SUPPLY_MASK, 8'h00);
        wr(`FLMR_OFS_INPUT_MASK, 8'h00);
        rd(`FLMR_OFS_SUPPLY_MASK, 8'h00);
        rd(`FLMR_OFS_INPUT_MASK, 8'h00);
    endtask

    // Each supply rises then falls; reading the first latch keeps it
    task automatic test_supply();
        for (int i = 0; i < 7; i++) begin
            set_lines(7'(1 << i), 4'h0, 1'b0);
            check1("summary", 1'b1, SUMMARY_FAULT_FLAG);
            rd(`FLMR_OFS_SUPPLY_LATCH, 8'h80 | 8'(1 << i));
            rd(`FLMR_OFS_SUPPLY_LATCH, 8'h80 | 8'(1 << i));
            rd(`FLMR_OFS_INPUT_LATCH, 8'h00);
            rd(`FLMR_OFS_SUPPLY_LATCH, 8'h00);
            check1("summary", 1'b0, SUMMARY_FAULT_FLAG);
            set_lines(7'h00, 4'h0, 1'b0);
            rd(`FLMR_OFS_SUPPLY_LATCH, 8'h80);
            rd(`FLMR_OFS_INPUT_LATCH, 8'h00);
        end
    endtask

    // Each general input and the watchdog, both directions
    task automatic test_inputs();
        logic [4:0] v;
        for (int i = 0; i < 5; i++) begin
            v = 5'(1 << i);
            set_lines(7'h00, v[3:0], v[4]);
            rd(`FLMR_OFS_SUPPLY_LATCH, 8'h80);
            rd(`FLMR_OFS_INPUT_LATCH, {3'b000, v});
            set_lines(7'h00, 4'h0, 1'b0);
            rd(`FLMR_OFS_INPUT_LATCH, {3'b000, v});
        end
    endtask

    // Clearing read taken on the very edge that logs a change: set wins
    task automatic test_race();
        @(negedge CLOCK);
        SUPPLY_FAULT_DETECTOR = 7'h04;
        @(negedge CLOCK);
        rd(`FLMR_OFS_INPUT_LATCH, 8'h00);
        check1("summary", 1'b1, SUMMARY_FAULT_FLAG);
        rd(`FLMR_OFS_SUPPLY_LATCH, 8'h84);
        rd(`FLMR_OFS_INPUT_LATCH, 8'h00);
        set_lines(7'h00, 4'h0, 1'b0);
        rd(`FLMR_OFS_INPUT_LATCH, 8'h00);
    endtask

    // Full masking logs nothing; one open bit per register still logs
    task automatic test_masking();
        wr(`FLMR_OFS_SUPPLY_MASK, 8'h7F);
        wr(`FLMR_OFS_INPUT_MASK, 8'h1F);
        set_lines(7'h7F, 4'hF, 1'b1);
        check1("summary", 1'b0, SUMMARY_FAULT_FLAG);
        rd(`FLMR_OFS_SUPPLY_LATCH, 8'h00);
        rd(`FLMR_OFS_INPUT_LATCH, 8'h00);
        set_lines(7'h00, 4'h0, 1'b0);
        wr(`FLMR_OFS_SUPPLY_MASK, 8'h7E);
        wr(`FLMR_OFS_INPUT_MASK, 8'h1E);
        set_lines(7'h7F, 4'hF, 1'b1);
        rd(`FLMR_OFS_SUPPLY_LATCH, 8'h81);
        rd(`FLMR_OFS_INPUT_LATCH, 8'h01);
        wr(`FLMR_OFS_SUPPLY_MASK, 8'h00);
        wr(`FLMR_OFS_INPUT_MASK, 8'h00);
        // Mask set after logging drops the already latched bit
        set_lines(7'h00, 4'h0, 1'b0);
        rd(`FLMR_OFS_SUPPLY_LATCH, 8'h80);
        wr(`FLMR_OFS_INPUT_MASK, 8'h01);
        rd(`FLMR_OFS_INPUT_LATCH, 8'h1E);
        wr(`FLMR_OFS_INPUT_MASK, 8'h00);
    endtask

    // Single exit for normal end and watchdog
    task automatic summarize();
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Main sequence, lines held low through reset to avoid stale events
    initial begin
        repeat (20) @(negedge CLOCK);
        SYS_RST = 1'b0;
        test_regs();
        test_supply();
        test_inputs();
        test_race();
        test_masking();
        summarize();
    end

    // Run needs well under 1000 cycles; stop a hang long before limits
    initial begin
        repeat (5000) @(posedge CLOCK);
        n_errors++;
        summarize();
    end
endmodule

`default_nettype wire
